// ===== rtl/mpo_defs.svh
// Purpose: Offsets, field positions, reset values and codes for the
//          motor phase output configuration block.
// Assumes: Avalon-MM word addressing, one 32-bit word per register.
// Notes:   All constants are macros; types live in the package.
//
// Summary of operation
// - Threshold code 00,01,10,11 selects 0.2V, 0.6V, 1.2V, 2.5V reference.
// - Edge-select bit: 0 detects falling zero crossing, 1 detects rising.
// - Hardware demag events pass only while hardware demag enable is set.
// - Software demag events pass only while software demag enable is set.
// - After D: low mode 00 even, 01 odd, 11 all, 10 alternate, or no PWM in voltage sensorless mode with upper clear.
// - Current sensorless C-D: upper clear even, set odd; sensor unused.
// - Of the mode bits only the upper is shadowed; low mode bits act on write.
// - Edge, demag enables, upper mode, input, channels wait for C.
// - Input select 00 input A, 01 input B, 10 input C, 11 unused.
// - Channel bits apply at next C, or on write with direct access.
// - Channel bit 0 is switch off, no PWM; 1 is active, PWM allowed.
// - Both registers read/write and reset to zero.
// - Pin level: polarity 0 gives 1 off/0 on; polarity 1 inverts that.
// - Direct access: all shadows load when phase state register is written.
// - Reads of shadowed registers give working, not pending, values.
`ifndef MPO_DEFS_SVH
`define MPO_DEFS_SVH

// Register word offsets
`define MPO_ADDR_CTRL 2'h0
`define MPO_ADDR_PHASE 2'h1
`define MPO_ADDR_MISC 2'h2
`define MPO_ADDR_POL 2'h3

// Reset values
`define MPO_CTRL_RESET 8'h00
`define MPO_PHASE_RESET 8'h00
`define MPO_MISC_RESET 8'h00
`define MPO_POL_RESET 6'h00

// Misc register field positions (sensor mode, current mode, direct access)
`define MPO_MISC_SENSOR_BIT 0
`define MPO_MISC_CURRENT_BIT 1
`define MPO_MISC_DIRECT_BIT 2

// Comparator input select codes
`define MPO_IN_A 2'h0
`define MPO_IN_B 2'h1
`define MPO_IN_C 2'h2

// Low PWM mode codes
`define MPO_PWM_EVEN 2'h0
`define MPO_PWM_ODD 2'h1
`define MPO_PWM_ALT 2'h2
`define MPO_PWM_ALL 2'h3

// Threshold in millivolts per code
`define MPO_VREF_0 12'h0C8
`define MPO_VREF_1 12'h258
`define MPO_VREF_2 12'h4B0
`define MPO_VREF_3 12'h9C4

`endif

// ===== rtl/mpo_pkg.sv
// Purpose: Types for the motor phase output configuration block.
// Assumes: Field layout macros come from mpo_defs.svh.
// Notes:   Struct field order matches register bit order.
`default_nettype none
package mpo_pkg;

   // Control register layout, bit 7 down to bit 0
   typedef struct packed {
      logic [1:0] sense_threshold_sel;
      logic zero_cross_edge_sel;
      logic hw_demag_enable;
      logic sw_demag_enable;
      logic pwm_mode_upper;
      logic [1:0] pwm_mode_low;
   } mpo_ctrl_type;

   // Phase state register layout
   typedef struct packed {
      logic [1:0] comparator_input_sel;
      logic [5:0] channel_on_bits;
   } mpo_phase_type;

   // PWM pattern chosen for one step interval
   typedef enum logic [2:0] {
      MPO_PWM_NONE = 3'b000,
      MPO_PWM_EVEN_CH = 3'b001,
      MPO_PWM_ODD_CH = 3'b010,
      MPO_PWM_ALT_CH = 3'b011,
      MPO_PWM_ALL_CH = 3'b100,
      MPO_PWM_CONT = 3'b101
   } mpo_pwm_type;

endpackage : mpo_pkg
`default_nettype wire

// ===== rtl/mpo_top.sv
// Purpose: Control and phase state registers with commutation shadowing,
//          comparator routing, demag gating and output pin levels.
// Assumes: Avalon-MM slave, 2-bit word address, 32-bit data.
// Notes:   Sense pins and comparator output are synchronised here.
//
// Chosen here: the Avalon-MM register port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "mpo_defs.svh"

module mpo_top
(
   // Clock, reset, enable
   input wire logic clk,
   input wire logic reset_n,
   input wire logic clk_en,
   // Avalon-MM slave
   input wire logic [1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // Commutation and demag events from the step logic
   input wire logic comm_event,
   input wire logic hw_demag_raw,
   input wire logic sw_demag_raw,
   input wire logic after_d,
   input wire logic pwm_in,
   // Comparator pins
   input wire logic sense_input_a,
   input wire logic sense_input_b,
   input wire logic sense_input_c,
   input wire logic comp_out,
   // Comparator control
   output logic [2:0] comp_mux_sel,
   output logic [11:0] vref_mv,
   // Events out
   output logic zero_cross_evt,
   output logic hw_demag_evt,
   output logic sw_demag_evt,
   // Channel outputs
   output logic [5:0] channel_out,
   output logic [5:0] channel_pwm_en
);

   ////////////////////////////////////////////////////////////////////////
   // Registers
   mpo_pkg::mpo_ctrl_type ctrl_work_r;
   mpo_pkg::mpo_ctrl_type ctrl_pend_r;
   mpo_pkg::mpo_phase_type phase_work_r;
   mpo_pkg::mpo_phase_type phase_pend_r;
   logic [7:0] misc_r;
   logic [5:0] channel_polarity_bits;
   logic [5:0] pol_r;
   logic ack_r;
   logic [2:0] sense_s1_r, sense_s2_r;
   logic comp_s1_r, comp_s2_r, comp_d_r;
   logic [5:0] chan_nxt;
   logic sensor_mode_sel, voltage_current_sel, direct_access;
   logic wr_ctrl, wr_phase, wr_misc, wr_pol, load_all, in_used;
   logic sensed_rise, sensed_fall, zc_hit;
   mpo_pkg::mpo_pwm_type pwm_sel;
   logic [5:0] pwm_mask;

   assign sensor_mode_sel = misc_r[`MPO_MISC_SENSOR_BIT];
   assign voltage_current_sel = misc_r[`MPO_MISC_CURRENT_BIT];
   assign direct_access = misc_r[`MPO_MISC_DIRECT_BIT];
   assign channel_polarity_bits = pol_r;

   ////////////////////////////////////////////////////////////////////////
   // Bus access: one wait cycle, answer on the second edge
   // Held while frozen, so no access completes without landing
   assign avs_waitrequest = (avs_read | avs_write) & (~ack_r | ~clk_en);
   assign wr_ctrl = avs_write & ack_r & avs_byteenable[0]
      & (avs_address == `MPO_ADDR_CTRL);
   assign wr_phase = avs_write & ack_r & avs_byteenable[0]
      & (avs_address == `MPO_ADDR_PHASE);
   assign wr_misc = avs_write & ack_r & avs_byteenable[0]
      & (avs_address == `MPO_ADDR_MISC);
   assign wr_pol = avs_write & ack_r & avs_byteenable[0]
      & (avs_address == `MPO_ADDR_POL);
   // Shadows load on C, or on a phase write under direct access
   assign load_all = comm_event | (wr_phase & direct_access);

   // Acknowledge toggles so each request takes exactly two edges
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         ack_r <= 1'b0;
      else if (clk_en)
         ack_r <= (avs_read | avs_write) & ~ack_r;
   end

   // Read data: working values only, pending shadows stay hidden
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         avs_readdata <= 32'h0000_0000;
      else if (clk_en && avs_read && !ack_r)
      begin
         if (avs_address == `MPO_ADDR_CTRL)
            avs_readdata <= {24'h00_0000, ctrl_work_r};
         else if (avs_address == `MPO_ADDR_PHASE)
            avs_readdata <= {24'h00_0000, phase_work_r};
         else if (avs_address == `MPO_ADDR_MISC)
            avs_readdata <= {24'h00_0000, misc_r};
         else
            avs_readdata <= {26'h000_0000, pol_r};
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Control register: threshold and low mode act on write
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         ctrl_work_r <= `MPO_CTRL_RESET;
         ctrl_pend_r <= `MPO_CTRL_RESET;
      end
      else if (clk_en)
      begin
         if (wr_ctrl)
            ctrl_pend_r <= avs_writedata[7:0];
         if (load_all)
         begin
            ctrl_work_r.zero_cross_edge_sel <= ctrl_pend_r.zero_cross_edge_sel;
            ctrl_work_r.hw_demag_enable <= ctrl_pend_r.hw_demag_enable;
            ctrl_work_r.sw_demag_enable <= ctrl_pend_r.sw_demag_enable;
            ctrl_work_r.pwm_mode_upper <= ctrl_pend_r.pwm_mode_upper;
         end
         if (wr_ctrl)
         begin
            ctrl_work_r.sense_threshold_sel <= avs_writedata[7:6];
            ctrl_work_r.pwm_mode_low <= avs_writedata[1:0];
         end
      end
   end

   // Phase state register: shadowed, written value pending until load
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         phase_work_r <= `MPO_PHASE_RESET;
         phase_pend_r <= `MPO_PHASE_RESET;
      end
      else if (clk_en)
      begin
         if (wr_phase)
            phase_pend_r <= avs_writedata[7:0];
         if (wr_phase && direct_access)
            phase_work_r <= avs_writedata[7:0];
         else if (comm_event)
            phase_work_r <= phase_pend_r;
      end
   end

   // Mode bits and polarity, plain registers
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         misc_r <= `MPO_MISC_RESET;
         pol_r <= `MPO_POL_RESET;
      end
      else if (clk_en)
      begin
         if (wr_misc)
            misc_r <= avs_writedata[7:0];
         if (wr_pol)
            pol_r <= avs_writedata[5:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisers; first stage feeds only the second
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         sense_s1_r <= 3'h0;
         sense_s2_r <= 3'h0;
         comp_s1_r <= 1'b0;
         comp_s2_r <= 1'b0;
         comp_d_r <= 1'b0;
      end
      else if (clk_en)
      begin
         sense_s1_r <= {sense_input_c, sense_input_b, sense_input_a};
         sense_s2_r <= sense_s1_r;
         comp_s1_r <= comp_out;
         comp_s2_r <= comp_s1_r;
         comp_d_r <= comp_s2_r;
      end
   end

   // Threshold code to reference level
   always_comb
   begin
      case (ctrl_work_r.sense_threshold_sel)
         2'h0: vref_mv = `MPO_VREF_0;
         2'h1: vref_mv = `MPO_VREF_1;
         2'h2: vref_mv = `MPO_VREF_2;
         default: vref_mv = `MPO_VREF_3;
      endcase
   end

   // One-hot comparator mux; code 11 leaves it open
   always_comb
   begin
      case (phase_work_r.comparator_input_sel)
         `MPO_IN_A: comp_mux_sel = 3'b001;
         `MPO_IN_B: comp_mux_sel = 3'b010;
         `MPO_IN_C: comp_mux_sel = 3'b100;
         default: comp_mux_sel = 3'b000;
      endcase
   end
   assign in_used = |comp_mux_sel;

   // Edge detection and event gating
   assign sensed_rise = comp_s2_r & ~comp_d_r;
   assign sensed_fall = ~comp_s2_r & comp_d_r;
   assign zc_hit = ctrl_work_r.zero_cross_edge_sel ? sensed_rise
      : sensed_fall;
   assign zero_cross_evt = in_used & zc_hit;
   assign hw_demag_evt = in_used & hw_demag_raw
      & ctrl_work_r.hw_demag_enable;
   assign sw_demag_evt = in_used & sw_demag_raw
      & ctrl_work_r.sw_demag_enable;

   ////////////////////////////////////////////////////////////////////////
   // PWM pattern selection for the current step interval
   always_comb
   begin
      pwm_sel = mpo_pkg::MPO_PWM_NONE;
      if (after_d || sensor_mode_sel)
      begin
         case (ctrl_work_r.pwm_mode_low)
            `MPO_PWM_EVEN: pwm_sel = mpo_pkg::MPO_PWM_EVEN_CH;
            `MPO_PWM_ODD: pwm_sel = mpo_pkg::MPO_PWM_ODD_CH;
            `MPO_PWM_ALL: pwm_sel = mpo_pkg::MPO_PWM_ALL_CH;
            default:
               if (!voltage_current_sel && !sensor_mode_sel
                   && !ctrl_work_r.pwm_mode_upper)
                  pwm_sel = mpo_pkg::MPO_PWM_CONT;
               else
                  pwm_sel = mpo_pkg::MPO_PWM_ALT_CH;
         endcase
      end
      else if (voltage_current_sel)
         pwm_sel = ctrl_work_r.pwm_mode_upper ? mpo_pkg::MPO_PWM_ODD_CH
            : mpo_pkg::MPO_PWM_EVEN_CH;
      else if (ctrl_work_r.pwm_mode_upper)
         pwm_sel = mpo_pkg::MPO_PWM_ALT_CH;
      else
      begin
         case (ctrl_work_r.pwm_mode_low)
            `MPO_PWM_EVEN: pwm_sel = mpo_pkg::MPO_PWM_EVEN_CH;
            `MPO_PWM_ODD: pwm_sel = mpo_pkg::MPO_PWM_ODD_CH;
            `MPO_PWM_ALL: pwm_sel = mpo_pkg::MPO_PWM_ALL_CH;
            default: pwm_sel = mpo_pkg::MPO_PWM_CONT;
         endcase
      end
   end

   // Channel mask: even channels are 0,2,4; alternate follows comm_event
   always_comb
   begin
      case (pwm_sel)
         mpo_pkg::MPO_PWM_EVEN_CH: pwm_mask = 6'h15;
         mpo_pkg::MPO_PWM_ODD_CH: pwm_mask = 6'h2A;
         mpo_pkg::MPO_PWM_ALT_CH: pwm_mask = comm_event ? 6'h15 : 6'h2A;
         mpo_pkg::MPO_PWM_ALL_CH: pwm_mask = 6'h3F;
         default: pwm_mask = 6'h00;
      endcase
   end

   // Direct access outputs plain levels, no PWM
   assign chan_nxt = phase_work_r.channel_on_bits
      & ~(pwm_mask & {6{~direct_access & ~pwm_in}});

   // Output pins from flops, polarity applied per channel
   genvar gi;
   generate
      for (gi = 0; gi < 6; gi = gi + 1)
      begin : g_chan
         always_ff @(posedge clk or negedge reset_n)
         begin
            if (!reset_n)
            begin
               channel_out[gi] <= 1'b1;
               channel_pwm_en[gi] <= 1'b0;
            end
            else if (clk_en)
            begin
               channel_out[gi] <= ~(chan_nxt[gi]
                  ^ channel_polarity_bits[gi]);
               channel_pwm_en[gi] <= phase_work_r.channel_on_bits[gi]
                  & pwm_mask[gi] & ~direct_access;
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // Checks
   sequence phase_write_s;
      avs_write && ack_r && avs_byteenable[0]
         && avs_address == `MPO_ADDR_PHASE;
   endsequence

   pend_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
      (phase_write_s and !direct_access and !comm_event and clk_en)
      |=> phase_work_r == $past(phase_work_r))
      else $error("phase work changed without a load");
   direct_load_a: assert property (@(posedge clk) disable iff (!reset_n)
      (phase_write_s and direct_access and clk_en)
      |=> phase_work_r == $past(avs_writedata[7:0]))
      else $error("direct access write not applied");
   comm_load_a: assert property (@(posedge clk) disable iff (!reset_n)
      (clk_en && comm_event && !wr_phase)
      |=> phase_work_r == $past(phase_pend_r))
      else $error("commutation did not load phase");
   low_mode_a: assert property (@(posedge clk) disable iff (!reset_n)
      (clk_en && wr_ctrl) |=> ctrl_work_r.pwm_mode_low
      == $past(avs_writedata[1:0]))
      else $error("low mode bits not immediate");
   unused_in_a: assert property (@(posedge clk) disable iff (!reset_n)
      phase_work_r.comparator_input_sel == 2'h3 |-> !zero_cross_evt
      && !hw_demag_evt && !sw_demag_evt)
      else $error("event with comparator unused");
   hw_gate_a: assert property (@(posedge clk) disable iff (!reset_n)
      hw_demag_evt |-> ctrl_work_r.hw_demag_enable)
      else $error("hw demag event while disabled");
   sw_gate_a: assert property (@(posedge clk) disable iff (!reset_n)
      sw_demag_evt |-> ctrl_work_r.sw_demag_enable)
      else $error("sw demag event while disabled");
   off_level_a: assert property (@(posedge clk) disable iff (!reset_n)
      (clk_en && !phase_work_r.channel_on_bits[0])
      |=> channel_out[0] == ~$past(pol_r[0]))
      else $error("off channel level wrong");
   edge_sel_a: assert property (@(posedge clk) disable iff (!reset_n)
      zero_cross_evt |-> (ctrl_work_r.zero_cross_edge_sel ? comp_s2_r
      : !comp_s2_r))
      else $error("zero crossing on wrong edge");

endmodule : mpo_top
`default_nettype wire

// ===== bench/mpo_stage_model.sv
// Purpose: Power stage sense network and back-EMF comparator model.
// Assumes: Phase levels in millivolts, compared with the reference.
// Notes:   An unselected comparator toggles every cycle, so a missing
//          input gate inside the block shows up as stray events.
`timescale 1ns/1ps
`default_nettype none

module mpo_stage_model
(
   // Clock
   input wire logic clk,
   // Phase levels from the bench
   input wire logic [11:0] phase_a_mv,
   input wire logic [11:0] phase_b_mv,
   input wire logic [11:0] phase_c_mv,
   // Comparator control from the block
   input wire logic [2:0] comp_mux_sel,
   input wire logic [11:0] vref_mv,
   // Sense pins and comparator output
   output logic sense_input_a,
   output logic sense_input_b,
   output logic sense_input_c,
   output logic comp_out
);
   logic float_r = 1'b0;

   ////////////////////////////////////////////////////////////////////////
   // Each sense pin reports its phase against the reference
   assign sense_input_a = phase_a_mv > vref_mv;
   assign sense_input_b = phase_b_mv > vref_mv;
   assign sense_input_c = phase_c_mv > vref_mv;

   // Open input never holds its last level
   always_ff @(posedge clk)
      float_r <= ~float_r;

   // Comparator input routing
   always_comb
      case (comp_mux_sel)
         3'b001: comp_out = sense_input_a;
         3'b010: comp_out = sense_input_b;
         3'b100: comp_out = sense_input_c;
         default: comp_out = float_r;
      endcase
endmodule : mpo_stage_model
`default_nettype wire

// ===== bench/tb_top.sv
// Purpose: Self-checking bench for the phase output configuration block.
// Assumes: Bus answer time comes from waitrequest; pwm_in high unless stated.
// Notes:   Expected values come from register rules, never from outputs.
`timescale 1ns/1ps
`default_nettype none

module tb_top;
   logic clk, reset_n, comm_event, hw_demag_raw, sw_demag_raw;
   logic after_d, pwm_in, avs_read, avs_write, avs_waitrequest;
   logic comp_out, zero_cross_evt, hw_demag_evt, sw_demag_evt;
   logic sense_input_a, sense_input_b, sense_input_c;
   logic [1:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata;
   logic [2:0] comp_mux_sel;
   logic [11:0] vref_mv, phase_c_mv;
   logic [5:0] channel_out, channel_pwm_en;
   logic [7:0] rd;
   int error_cnt, checks;
   logic [11:0] vref_tab [4] = '{12'h0C8, 12'h258, 12'h4B0, 12'h9C4};

   ////////////////////////////////////////////////////////////////////////
   mpo_top uut
   (
      .clk(clk), .reset_n(reset_n), .clk_en(1'b1),
      .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .comm_event(comm_event),
      .hw_demag_raw(hw_demag_raw), .sw_demag_raw(sw_demag_raw),
      .after_d(after_d), .pwm_in(pwm_in), .sense_input_a(sense_input_a),
      .sense_input_b(sense_input_b), .sense_input_c(sense_input_c),
      .comp_out(comp_out), .comp_mux_sel(comp_mux_sel), .vref_mv(vref_mv),
      .zero_cross_evt(zero_cross_evt), .hw_demag_evt(hw_demag_evt),
      .sw_demag_evt(sw_demag_evt), .channel_out(channel_out),
      .channel_pwm_en(channel_pwm_en)
   );

   // Far side: phase A and B held low, phase C swept by the bench
   mpo_stage_model stage
   (
      .clk(clk), .phase_a_mv(12'h000), .phase_b_mv(12'h000),
      .phase_c_mv(phase_c_mv), .comp_mux_sel(comp_mux_sel),
      .vref_mv(vref_mv), .sense_input_a(sense_input_a),
      .sense_input_b(sense_input_b), .sense_input_c(sense_input_c),
      .comp_out(comp_out)
   );

   // 40 MHz clock
   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   ////////////////////////////////////////////////////////////////////////
   task automatic end_sim;
      $display("errors %0d checks %0d", error_cnt, checks);
      if (error_cnt == 0 && checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : end_sim

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp)
      begin
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
         error_cnt++;
      end
   endtask : chk

   // One access; request held until waitrequest is low at a rising edge
   task automatic bus(input logic wr, input logic [1:0] a,
                      input logic [7:0] d);
      int i;
      avs_address <= a;
      avs_writedata <= {24'h000000, d};
      avs_write <= wr;
      avs_read <= !wr;
      for (i = 0; i < 20; i++)
      begin
         @(posedge clk);
         if (avs_waitrequest === 1'b0)
            break;
      end
      if (i == 20)
      begin
         error_cnt++;
         end_sim();
      end
      rd = avs_readdata[7:0];
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge clk);
   endtask : bus

   task automatic rdchk(input logic [1:0] a, input logic [7:0] exp);
      bus(1'b0, a, 8'h00);
      chk({24'h000000, rd}, {24'h000000, exp});
   endtask : rdchk

   // Control write, then one edge for the registered enables to land
   task automatic pwmchk(input logic [7:0] c, input logic [5:0] exp);
      bus(1'b1, 2'h0, c);
      @(posedge clk);
      chk({26'h0, channel_pwm_en}, {26'h0, exp});
   endtask : pwmchk

   // Commutation pulse, then time for registered outputs to land
   task automatic comm;
      comm_event <= 1'b1;
      @(posedge clk);
      comm_event <= 1'b0;
      repeat (3) @(posedge clk);
   endtask : comm

   task automatic demag(input logic hw, input logic exp);
      hw_demag_raw <= hw;
      sw_demag_raw <= !hw;
      @(negedge clk);
      chk({31'h0, hw ? hw_demag_evt : sw_demag_evt}, {31'h0, exp});
      @(posedge clk);
      hw_demag_raw <= 1'b0;
      sw_demag_raw <= 1'b0;
      @(posedge clk);
   endtask : demag

   // Count zero-crossing pulses after moving phase C
   task automatic zc(input logic [11:0] mv, input int exp);
      int k;
      k = 0;
      phase_c_mv <= mv;
      repeat (8)
      begin
         @(negedge clk);
         if (zero_cross_evt === 1'b1)
            k++;
      end
      @(posedge clk);
      chk(k, exp);
   endtask : zc

   ////////////////////////////////////////////////////////////////////////
   initial
   begin
      reset_n = 1'b0;
      comm_event = 1'b0;
      hw_demag_raw = 1'b0;
      sw_demag_raw = 1'b0;
      after_d = 1'b1;
      pwm_in = 1'b1;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_address = 2'h0;
      avs_writedata = 32'h00000000;
      phase_c_mv = 12'h000;
      repeat (5) @(posedge clk);
      reset_n <= 1'b1;
      @(posedge clk);
      rdchk(2'h0, 8'h00);
      rdchk(2'h1, 8'h00);
      chk(channel_out, 6'h3F);
      for (int t = 0; t < 4; t++)
      begin
         bus(1'b1, 2'h0, {t[1:0], 6'h00});
         chk(vref_mv, vref_tab[t]);
      end
      // Threshold and low mode act at once, the rest waits for C
      bus(1'b1, 2'h0, 8'h3B);
      rdchk(2'h0, 8'h03);
      demag(1'b1, 1'b0);
      comm();
      rdchk(2'h0, 8'h3B);
      demag(1'b1, 1'b1);
      demag(1'b0, 1'b1);
      bus(1'b1, 2'h1, 8'h85);
      rdchk(2'h1, 8'h00);
      chk(channel_out, 6'h3F);
      comm();
      rdchk(2'h1, 8'h85);
      chk(comp_mux_sel, 3'b100);
      chk(channel_out, 6'h3A);
      chk(channel_pwm_en, 6'h05);
      pwm_in <= 1'b0;
      repeat (3) @(posedge clk);
      chk(channel_out, 6'h3F);
      pwm_in <= 1'b1;
      zc(12'hFFF, 1);
      zc(12'h000, 0);
      bus(1'b1, 2'h3, 8'h3F);
      comm();
      chk(channel_out, 6'h05);
      // Unused input code: toggling comparator must stay silent
      bus(1'b1, 2'h1, 8'hC5);
      comm();
      chk(comp_mux_sel, 3'b000);
      zc(12'hFFF, 0);
      // PWM pattern per mode and interval, every channel on
      bus(1'b1, 2'h1, 8'hFF);
      comm();
      pwmchk(8'h38, 6'h15);
      pwmchk(8'h39, 6'h2A);
      pwmchk(8'h3A, 6'h00);
      after_d <= 1'b0;
      pwmchk(8'h38, 6'h15);
      bus(1'b1, 2'h0, 8'h3C);
      comm();
      chk(channel_pwm_en, 6'h2A);
      bus(1'b1, 2'h2, 8'h02);
      pwmchk(8'h38, 6'h2A);
      comm();
      chk(channel_pwm_en, 6'h15);
      // Sensor mode ignores the upper bit before D
      bus(1'b1, 2'h2, 8'h01);
      bus(1'b1, 2'h0, 8'h3F);
      comm();
      chk(channel_pwm_en, 6'h3F);
      after_d <= 1'b1;
      // Direct access: phase write loads every shadow at once
      bus(1'b1, 2'h2, 8'h04);
      bus(1'b1, 2'h0, 8'h00);
      bus(1'b1, 2'h1, 8'h42);
      repeat (2) @(posedge clk);
      chk(channel_out, 6'h02);
      chk(comp_mux_sel, 3'b010);
      rdchk(2'h0, 8'h00);
      demag(1'b0, 1'b0);
      // Second reset in mid-run
      reset_n <= 1'b0;
      repeat (5) @(posedge clk);
      reset_n <= 1'b1;
      @(posedge clk);
      rdchk(2'h1, 8'h00);
      chk(channel_out, 6'h3F);
      end_sim();
   end
endmodule : tb_top
`default_nettype wire
